// >>> hdl/ias_pkg.sv
// Shared constants and types for the two-wire memory access sequencer.
// Assumes a single 10 MHz clock and bus pins sampled as synchronous inputs.
package ias_pkg;

   // Slave address byte: space code in bits 7:4, select bits in 3:1
   localparam logic [3:0] ARRAY_ID = 4'ha;
   localparam logic [3:0] REG_ID = 4'hd;
   localparam logic [2:0] DEV_SEL = 3'h7;

   // Storage sizes and index widths
   localparam int ARRAY_BYTES = 512;
   localparam int REG_BYTES = 64;
   localparam int ARRAY_AW = 9;
   localparam int REG_AW = 6;

   // Page masks for write rollover
   localparam logic [15:0] ARRAY_PAGE_MASK = 16'h000f;
   localparam logic [15:0] REG_PAGE_MASK = 16'h0007;

   // Address counter value after reset
   localparam logic [15:0] PTR_RESET = 16'h0000;

   // Internal write cycle: time in microseconds, clock in MHz, derived cycles
   localparam int T_WR_US = 5000;
   localparam int CLK_MHZ = 10;
   localparam int WR_CYCLES = T_WR_US * CLK_MHZ;

   // Commit FIFO shape: one space bit, nine address bits, eight data bits
   localparam int FIFO_DEPTH = 16;
   localparam int ENTRY_W = 18;

   // Bus-side sequencer states
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_DEV,
      ST_WHI,
      ST_WLO,
      ST_WDATA,
      ST_RDATA,
      ST_IGNORE,
      ST_COPY,
      ST_BUSY
   } ias_state_t;

endpackage

// >>> hdl/ias_stream_if.sv
// Valid/ready word stream between the sequencer and its commit FIFO.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface ias_stream_if #(parameter int W = 8) ();
   logic valid; // Word offered
   logic ready; // Word accepted when both high
   logic [W-1:0] data; // Word content

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// >>> hdl/ias_fifo.sv
// Synchronous FIFO built from flip-flops, valid/ready on both sides.
// Assumes one clock, synchronous active-high reset and a freezing enable.
`timescale 1ns/100ps
module ias_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   ias_stream_if.snk in_s,
   ias_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);

   // Whole FIFO state in one record
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage words
      logic [AW-1:0] wp; // Write index
      logic [AW-1:0] rp; // Read index
      logic [AW:0] cnt; // Fill level, one bit wider so full is exact
   } ias_fifo_t;

   ias_fifo_t s;
   ias_fifo_t next_s;
   logic push;
   logic pop;

   // Honest flags straight from the fill level
   assign in_s.ready = (s.cnt != (AW+1)'(DEPTH));
   assign out_s.valid = (s.cnt != '0);
   assign out_s.data = s.mem[s.rp];

   // Next state: push and pop may happen in the same cycle
   always_comb begin
      next_s = s;
      push = in_s.valid & in_s.ready;
      pop = out_s.valid & out_s.ready;
      if (push) begin
         next_s.mem[s.wp] = in_s.data;
         next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
      end
      if (pop) begin
         next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
      end
      // Level moves only when exactly one side acts
      if (push && !pop) begin
         next_s.cnt = s.cnt + 1'b1;
      end else if (pop && !push) begin
         next_s.cnt = s.cnt - 1'b1;
      end
   end

   // State register, frozen while the enable is low
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end
endmodule

// >>> hdl/ias_top.sv
// Two-wire slave sequencer for a 512-byte nonvolatile array and a
// 64-byte clock/control register space, with an internal write cycle.
// Assumes SCL and SDA already synchronous to MCLK_IN; SDA is open drain.
//
// How it works
// R1: Space code 1010 or 1101, select 111
// R2: No acknowledge on a foreign slave byte
// R3: Random read repeats the same slave byte
// R4: Byte write: slave, two addresses, data
// R5: Master unlocks register writes first
// R6: Write cycle after stop, bus ignored
// R7: Protected write acknowledged, discarded, no cycle
// R8: Page holds sixteen or eight bytes
// R9: Clock registers written as full page
// R10: Write address wraps within its page
// R11: Excess bytes overwrite earlier page bytes
// R12: Early stop aborts without any write
// R13: Polling unanswered until cycle completes
// R14: Master polls only with array byte
// R15: Counter starts at zero, last plus one; after a write the code leaves it on the last byte written
// R16: Read byte acknowledged then data shifted
// R17: Master ends read with no acknowledge
// R18: Random read: dummy write, repeated start
// R19: Stop after address sets counter, standby
// R20: Master acknowledge requests next byte
// R21: Read counter wraps over whole space
// R22: Word address sent high byte first
`timescale 1ns/100ps
module ias_top
   import ias_pkg::*;
#(
   parameter int unsigned WR_CYCLES_P = WR_CYCLES
) (
   input wire logic MCLK_IN,
   input wire logic RESET_IN,
   input wire logic CLK_EN_IN,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   input wire logic WRITE_PROTECT_IN,
   output logic SDA_OUT,
   output logic SDA_OE_OUT,
   output logic BUSY_OUT
);

   // All sequencer state in one record
   typedef struct packed {
      ias_state_t st; // Bus sequencer state
      logic scl_q; // SCL one cycle ago
      logic sda_q; // SDA one cycle ago
      logic [3:0] bcnt; // Bit position within the nine-clock frame
      logic [7:0] sh; // Shift register, both directions
      logic sda_oe; // Pulling SDA low
      logic rw; // Read bit of the slave byte
      logic space; // 0 array, 1 clock/control register space
      logic mack; // Master acknowledged the last read byte
      logic got_data; // A full data byte and its acknowledge went by
      logic [7:0] hi; // High word address byte
      logic [15:0] ptr; // Address counter
      logic [15:0] waddr; // Next page write location
      logic [15:0] bvalid; // Page staging slots loaded
      logic [15:0][7:0] pbuf; // Page staging bytes
      logic [4:0] idx; // Commit walk index
      logic [15:0] timer; // Write cycle countdown
      logic [ARRAY_BYTES-1:0][7:0] arr; // Nonvolatile array
      logic [REG_BYTES-1:0][7:0] regs; // Clock/control register space
   } ias_core_t;

   ias_core_t s;
   ias_core_t next_s;
   logic rise; // SCL rising edge
   logic fall; // SCL falling edge
   logic start; // Start or repeated start
   logic stop; // Stop
   logic [7:0] rd_byte; // Byte at the address counter
   logic [15:0] rd_next; // Counter after a read byte
   logic [15:0] wr_next; // Page write location after a byte
   logic [15:0] page_mask; // Rollover mask of the current space
   logic [ENTRY_W-1:0] drain; // Word leaving the FIFO

   ias_stream_if #(.W(ENTRY_W)) fin ();
   ias_stream_if #(.W(ENTRY_W)) fout ();

   // The FIFO decouples the staging walk from the memory write; its depth
   // equals the largest page, so a full page never stalls the walk.
   // Staged page goes through the FIFO; a full FIFO holds the commit walk
   ias_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(MCLK_IN),
      .rst(RESET_IN),
      .ce(CLK_EN_IN),
      .in_s(fin.snk),
      .out_s(fout.src)
   );

   // Commit walk offers loaded slots in ascending order
   assign fin.valid = (s.st == ST_COPY) && !s.idx[4] && s.bvalid[s.idx[3:0]];
   assign fin.data = {s.space, s.waddr[8:4], s.idx[3:0], s.pbuf[s.idx[3:0]]};
   // Memory is only written while the write cycle runs
   assign fout.ready = (s.st == ST_BUSY); // R6
   assign drain = fout.data;

   // Bus conditions from the sampled pins
   assign rise = SCL_IN & ~s.scl_q;
   assign fall = ~SCL_IN & s.scl_q;
   assign start = SCL_IN & s.scl_q & s.sda_q & ~SDA_IN;
   assign stop = SCL_IN & s.scl_q & ~s.sda_q & SDA_IN;

   // Reads wrap over the whole space of the selected target; the page mask
   // only matters for writes.
   // Read source and counter advance per space
   always_comb begin
      if (s.space) begin
         rd_byte = s.regs[s.ptr[REG_AW-1:0]];
         rd_next = {10'h000, s.ptr[REG_AW-1:0] + 6'h01}; // R21
         page_mask = REG_PAGE_MASK;
      end else begin
         rd_byte = s.arr[s.ptr[ARRAY_AW-1:0]];
         rd_next = {7'h00, s.ptr[ARRAY_AW-1:0] + 9'h001}; // R21
         page_mask = ARRAY_PAGE_MASK;
      end
      // Low bits advance, page bits stay put
      wr_next = (s.waddr & ~page_mask) | ((s.waddr + 16'h0001) & page_mask); // R10
   end

   // The data pin value is fixed low and only the enable moves, so the pin
   // can never fight a master that drives high.
   // Pins: open drain, only ever pulls low
   assign SDA_OUT = 1'b0;
   assign SDA_OE_OUT = s.sda_oe;
   assign BUSY_OUT = (s.st == ST_COPY) || (s.st == ST_BUSY);

   // Frame timing, in cycles of MCLK_IN:
   // - a bit is taken on the cycle that first sees SCL high after low;
   // - the data drive only changes on the cycle that first sees SCL low,
   //   so the master never sees it move while SCL is high;
   // - a stop commits only in the first clock of a new byte, that is right
   //   after a data byte and its acknowledge went by.
   // Starts and stops are ignored outright while busy, which is what makes
   // acknowledge polling work: the slave byte simply gets no answer.
   // Sequencer next state
   always_comb begin
      next_s = s;
      next_s.scl_q = SCL_IN;
      next_s.sda_q = SDA_IN;
      if (s.st == ST_COPY) begin
         // Bus ignored; walk slots, stalling while the FIFO is full
         next_s.sda_oe = 1'b0; // R6
         if (s.idx[4]) begin
            next_s.st = ST_BUSY;
            next_s.timer = 16'(WR_CYCLES_P - 1);
         end else if (!s.bvalid[s.idx[3:0]] || fin.ready) begin
            next_s.idx = s.idx + 5'h01;
         end
      end else if (s.st == ST_BUSY) begin
         // Write cycle: inputs dead, no acknowledge for polling
         next_s.sda_oe = 1'b0; // R6 R13
         if (fout.valid) begin
            // Each loaded slot lands once; a wrapped byte already replaced its slot in staging
            if (drain[ENTRY_W-1]) begin
               next_s.regs[drain[8+REG_AW-1:8]] = drain[7:0]; // R11
            end else begin
               next_s.arr[drain[8+ARRAY_AW-1:8]] = drain[7:0]; // R11
            end
         end
         if (s.timer != 16'h0000) begin
            next_s.timer = s.timer - 16'h0001;
         end else if (!fout.valid) begin
            // Done: the next slave byte is acknowledged again
            next_s.st = ST_IDLE; // R13
         end
      end else if (start) begin
         // Start or repeated start always opens a slave byte
         next_s.st = ST_DEV;
         next_s.bcnt = 4'h0;
         next_s.sda_oe = 1'b0;
         next_s.got_data = 1'b0;
      end else if (stop) begin
         next_s.sda_oe = 1'b0;
         next_s.st = ST_IDLE; // R19
         // Commit only after a whole data byte and acknowledge, not mid-byte
         // The stop's own SCL rise already counted as the first bit of a new
         // byte, so a clean end shows exactly one bit taken
         if (s.st == ST_WDATA && s.got_data && s.bcnt == 4'h1) begin // R12
            if (!s.space && WRITE_PROTECT_IN) begin
               // Acknowledged but dropped; no write cycle follows
               next_s.st = ST_IDLE; // R7
            end else begin
               next_s.st = ST_COPY; // R6
               next_s.idx = 5'h00;
            end
         end
      end else begin
         unique case (s.st)
            ST_DEV, ST_WHI, ST_WLO, ST_WDATA: begin
               if (rise && s.bcnt < 4'h8) begin
                  // Receive most significant bit first
                  next_s.sh = {s.sh[6:0], SDA_IN};
                  next_s.bcnt = s.bcnt + 4'h1;
               end else if (fall && s.bcnt == 4'h8) begin
                  // Byte complete: decide the acknowledge
                  next_s.bcnt = 4'h9;
                  next_s.sda_oe = 1'b1; // R4
                  if (s.st == ST_DEV) begin
                     if ((s.sh[7:4] == ARRAY_ID || s.sh[7:4] == REG_ID)
                           && s.sh[3:1] == DEV_SEL) begin // R1
                        next_s.space = (s.sh[7:4] == REG_ID);
                        next_s.rw = s.sh[0];
                     end else begin
                        next_s.sda_oe = 1'b0; // R2
                        next_s.st = ST_IGNORE;
                     end
                  end else if (s.st == ST_WHI) begin
                     next_s.hi = s.sh; // R22
                  end else if (s.st == ST_WLO) begin
                     // Counter loaded here, so a stop now just sets it
                     next_s.ptr = {s.hi, s.sh}; // R22 R19
                     next_s.waddr = {s.hi, s.sh};
                     next_s.bvalid = 16'h0000;
                  end else begin
                     // Stage the byte; a wrapped slot simply takes the new one
                     next_s.pbuf[s.waddr[3:0]] = s.sh; // R11
                     next_s.bvalid[s.waddr[3:0]] = 1'b1;
                     next_s.ptr = s.waddr; // R10
                     next_s.waddr = wr_next; // R10 R8
                  end
               end else if (fall && s.bcnt == 4'h9) begin
                  // Acknowledge clock over: release and move on
                  next_s.sda_oe = 1'b0;
                  next_s.bcnt = 4'h0;
                  unique case (s.st)
                     ST_DEV: begin
                        if (s.rw) begin
                           // First read byte from the counter
                           next_s.st = ST_RDATA; // R16
                           next_s.sh = rd_byte; // R15
                           next_s.sda_oe = ~rd_byte[7];
                           next_s.ptr = rd_next; // R15
                        end else begin
                           next_s.st = ST_WHI; // R4
                        end
                     end
                     ST_WHI: next_s.st = ST_WLO;
                     ST_WLO: next_s.st = ST_WDATA;
                     default: next_s.got_data = 1'b1; // R12
                  endcase
               end
            end
            ST_RDATA: begin
               if (rise && s.bcnt < 4'h8) begin
                  // Bit taken by master; line up the next one
                  next_s.sh = {s.sh[6:0], 1'b0};
                  next_s.bcnt = s.bcnt + 4'h1;
               end else if (rise && s.bcnt == 4'h8) begin
                  // Ninth clock: low line means the master wants more
                  next_s.mack = ~SDA_IN; // R20 R17
                  next_s.bcnt = 4'h9;
               end else if (fall && s.bcnt < 4'h8) begin
                  next_s.sda_oe = ~s.sh[7]; // R16
               end else if (fall && s.bcnt == 4'h8) begin
                  next_s.sda_oe = 1'b0;
               end else if (fall && s.bcnt == 4'h9) begin
                  next_s.bcnt = 4'h0;
                  if (s.mack) begin
                     // Sequential read across pages, wrapping at the end
                     next_s.sh = rd_byte; // R20
                     next_s.sda_oe = ~rd_byte[7];
                     next_s.ptr = rd_next; // R21
                  end else begin
                     // No acknowledge: stop sending until next start
                     next_s.st = ST_IGNORE; // R20
                  end
               end
            end
            // Idle and ignore wait for a start; busy states handled above
            default: begin
               next_s.sda_oe = 1'b0;
            end
         endcase
      end
   end

   // Reset takes the previous pin samples as high, so an idle bus just after
   // reset looks like neither a start nor a stop.
   // Clearing the storage on reset is a modelling convenience; a real
   // nonvolatile array would keep its contents across a reset.
   // State register; memories clear only with the reset, counter to zero
   always_ff @(posedge MCLK_IN) begin
      if (RESET_IN) begin
         s <= '0; // R15
         s.ptr <= PTR_RESET; // R15
         s.scl_q <= 1'b1;
         s.sda_q <= 1'b1;
      end else if (CLK_EN_IN) begin
         s <= next_s;
      end
   end
endmodule

// >>> tb/ias_top_monitor.sv
// Checker for the two-wire sequencer top, bound onto its ports.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/100ps
module ias_top_checker #(
   parameter int unsigned WR_CYCLES_P = 20
) (
   input wire logic MCLK_IN,
   input wire logic RESET_IN,
   input wire logic CLK_EN_IN,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   input wire logic WRITE_PROTECT_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE_OUT,
   input wire logic BUSY_OUT
);
   int unsigned busy_len; // Busy cycles so far
   // Length of the current busy stretch, cleared when idle; frozen cycles
   // do not count, since the design's timer stands still then too
   always_ff @(posedge MCLK_IN) begin
      if (RESET_IN || !BUSY_OUT) begin
         busy_len <= 0;
      end else if (CLK_EN_IN) begin
         busy_len <= busy_len + 1;
      end
   end
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (RESET_IN);
   pin_low_a: assert property (SDA_OUT == 1'b0)
      else $error("data value not low");
   busy_quiet_a: assert property (BUSY_OUT |-> !SDA_OE_OUT)
      else $error("driving while busy");
   oe_on_fall_a: assert property ($changed(SDA_OE_OUT)
      |-> $past(SCL_IN, 2) && !$past(SCL_IN))
      else $error("drive changed off a clock fall");
   oe_scl_low_a: assert property ($rose(SDA_OE_OUT) |-> !SCL_IN)
      else $error("acknowledge raised with clock high");
   busy_idle_a: assert property ($rose(BUSY_OUT) |-> SCL_IN && SDA_IN)
      else $error("busy began outside a stop");
   busy_min_a: assert property ($fell(BUSY_OUT) |-> busy_len >= WR_CYCLES_P)
      else $error("write cycle too short");
   busy_max_a: assert property (BUSY_OUT |-> busy_len <= WR_CYCLES_P + 300)
      else $error("write cycle too long");
   start_free_a: assert property (SCL_IN && $past(SCL_IN) && $fell(SDA_IN)
      |=> !SDA_OE_OUT [*2])
      else $error("driving right after a start");
   reset_quiet_a: assert property (disable iff (1'b0)
      RESET_IN && CLK_EN_IN |=> !SDA_OE_OUT && !BUSY_OUT)
      else $error("outputs active after reset");
   cover property ($rose(BUSY_OUT));
   cover property ($fell(BUSY_OUT));
   cover property ($rose(SDA_OE_OUT));
endmodule
bind ias_top ias_top_checker #(.WR_CYCLES_P(WR_CYCLES_P)) ias_top_checker_i (
   .MCLK_IN(MCLK_IN), .RESET_IN(RESET_IN), .CLK_EN_IN(CLK_EN_IN), .SCL_IN(SCL_IN),
   .SDA_IN(SDA_IN), .WRITE_PROTECT_IN(WRITE_PROTECT_IN), .SDA_OUT(SDA_OUT),
   .SDA_OE_OUT(SDA_OE_OUT), .BUSY_OUT(BUSY_OUT));

// >>> tb/ias_master.sv
// Two-wire bus master model; the bench calls its tasks one at a time.
// Assumes a pull-up on data: a released line reads high.
`timescale 1ns/100ps
module ias_master (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_drv
);
   int half_n = 4; // Cycles per clock level; raise it for a slow master
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task half;
      repeat (half_n) @(posedge clk);
   endtask
   // Data set while clock is low, read back late in the high level
   task bit_io(input logic b, output logic r);
      sda_drv <= b;
      half();
      scl <= 1'b1;
      half();
      r = sda_line;
      scl <= 1'b0;
      @(posedge clk);
   endtask
   // Also serves as repeated start when the clock is low
   task start;
      sda_drv <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      sda_drv <= 1'b0;
      half();
      scl <= 1'b0;
      half();
   endtask
   task stop;
      sda_drv <= 1'b0;
      half();
      scl <= 1'b1;
      half();
      sda_drv <= 1'b1;
      half();
   endtask
   task send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task recv(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(~more, r);
   endtask
endmodule

// >>> tb/ias_top_test.sv
// Self-checking bench for the two-wire sequencer top.
// Assumes the master model and a pull-up on the data line.
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module ias_top_test;
   import ias_pkg::*;
   localparam int WRC = 300; // Short write cycle, still longer than one poll
   localparam logic [15:0] STAT_ADDR = 16'h003f; // Status location, arbitrary
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic wp = 1'b0;
   logic ce = 1'b1; // Clock enable; low freezes the whole design
   logic scl, sda_m, sda, sda_o, oe, busy;
   logic [7:0] arr [512]; // Expected array contents
   logic [7:0] reg_m [64]; // Expected register contents
   logic [15:0] ptr = 16'h0000; // Expected address counter
   logic [7:0] q [$]; // Bytes for the next write
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   assign sda = sda_m & (oe ? sda_o : 1'b1);
   ias_top #(.WR_CYCLES_P(WRC)) ias_top_i (.MCLK_IN(mclk), .RESET_IN(rst), .CLK_EN_IN(ce),
      .SCL_IN(scl), .SDA_IN(sda), .WRITE_PROTECT_IN(wp), .SDA_OUT(sda_o),
      .SDA_OE_OUT(oe), .BUSY_OUT(busy));
   ias_master ias_master_i (.clk(mclk), .sda_line(sda), .scl(scl), .sda_drv(sda_m));
   always #50 mclk = ~mclk;
   // Hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fail_count++;
         print_verdict();
      end
   end
   task print_verdict;
      $display("checks %0d, errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task busy_is(input logic want);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      `CHK(busy, want)
      @(posedge mclk);
   endtask
   task drain;
      for (int n = 0; n < WRC + 400 && busy === 1'b1; n++) @(posedge mclk);
      `CHK(busy, 1'b0)
   endtask
   // Write q at address a; the pointer rests on the last byte written
   task put(input logic [7:0] sb, input logic [15:0] a, input logic want);
      logic k;
      logic [15:0] p;
      p = a;
      ias_master_i.start();
      ias_master_i.send(sb, k); `CHK(k, 1'b1)
      ias_master_i.send(a[15:8], k); `CHK(k, 1'b1)
      ias_master_i.send(a[7:0], k); `CHK(k, 1'b1)
      foreach (q[i]) begin
         ias_master_i.send(q[i], k); `CHK(k, 1'b1)
         p = sb[4] ? {a[15:3], a[2:0] + 3'(i)} : {a[15:4], a[3:0] + 4'(i)};
         if (sb[4]) reg_m[p[5:0]] = q[i];
         else if (!wp) arr[p[8:0]] = q[i];
      end
      ias_master_i.stop();
      // The counter follows the written address even when the data is dropped
      ptr = p;
      busy_is(want);
   endtask
   // Read n bytes, random when rnd is set, current address otherwise
   task get(input logic [7:0] sb, input logic [15:0] a, input logic rnd, input int n);
      logic k;
      logic [7:0] d;
      ias_master_i.start();
      if (rnd) begin
         ias_master_i.send(sb & 8'hfe, k);
         ias_master_i.send(a[15:8], k);
         ias_master_i.send(a[7:0], k);
         ias_master_i.start();
         ptr = a;
      end
      ias_master_i.send(sb | 8'h01, k); `CHK(k, 1'b1)
      for (int j = 0; j < n; j++) begin
         ias_master_i.recv(j < n - 1, d);
         `CHK(d, sb[4] ? reg_m[ptr[5:0]] : arr[ptr[8:0]])
         ptr = ptr + 16'h0001;
      end
      ias_master_i.stop();
   endtask
   task t_foreign;
      logic k;
      ias_master_i.start();
      ias_master_i.send(8'ha0, k); `CHK(k, 1'b0)
      ias_master_i.stop();
      ias_master_i.start();
      ias_master_i.send(8'h5e, k); `CHK(k, 1'b0)
      ias_master_i.stop();
   endtask
   task t_poll;
      logic k;
      q = '{8'h55};
      put(8'hae, 16'h0012, 1'b1);
      ias_master_i.start();
      ias_master_i.send(8'hae, k); `CHK(k, 1'b0)
      ias_master_i.stop();
      drain();
      ias_master_i.start();
      ias_master_i.send(8'hae, k); `CHK(k, 1'b1)
      ias_master_i.stop();
      get(8'haf, 16'h0012, 1'b1, 1);
   endtask
   task t_page;
      q = {};
      for (int j = 0; j < 18; j++) q.push_back(8'h80 + 8'(j));
      put(8'hae, 16'h001a, 1'b1);
      drain();
      get(8'haf, 16'h0010, 1'b1, 16);
   endtask
   task t_wrap;
      q = '{8'h9c};
      put(8'hae, 16'h01ff, 1'b1);
      drain();
      q = {};
      put(8'hae, 16'h01ff, 1'b0);
      get(8'haf, 16'h0000, 1'b0, 2);
   endtask
   // Stop in the middle of the second data byte
   task t_abort;
      logic k;
      ias_master_i.start();
      ias_master_i.send(8'hae, k);
      ias_master_i.send(8'h00, k);
      ias_master_i.send(8'h30, k);
      ias_master_i.send(8'h77, k);
      for (int j = 0; j < 4; j++) ias_master_i.bit_io(1'b0, k);
      ias_master_i.stop();
      busy_is(1'b0);
      get(8'haf, 16'h0030, 1'b1, 1);
   endtask
   task t_protect;
      wp <= 1'b1;
      q = '{8'haa};
      put(8'hae, 16'h0040, 1'b0);
      wp <= 1'b0;
      get(8'haf, 16'h0040, 1'b1, 1);
   endtask
   // Enable held low longer than a whole write cycle: busy must not end,
   // and the write still lands once the enable returns
   task t_freeze;
      q = '{8'h3c};
      put(8'hae, 16'h0100, 1'b1);
      ce <= 1'b0;
      repeat (WRC + 100) @(posedge mclk);
      @(negedge mclk);
      `CHK(busy, 1'b1)
      @(posedge mclk);
      ce <= 1'b1;
      drain();
      get(8'haf, 16'h0100, 1'b1, 1);
   endtask
   // Unlock pair, then a full register page, with a slow master
   task t_regs;
      ias_master_i.half_n = 6;
      for (int j = 0; j < 2; j++) begin
         q = '{j ? 8'h06 : 8'h02};
         put(8'hde, STAT_ADDR, 1'b1);
         drain();
      end
      q = {};
      for (int j = 0; j < 8; j++) q.push_back(8'h40 + 8'(j));
      put(8'hde, 16'h0030, 1'b1);
      drain();
      get(8'hdf, 16'h0030, 1'b1, 8);
      ias_master_i.half_n = 4;
   endtask
   initial begin
      for (int j = 0; j < 512; j++) arr[j] = 8'h00;
      for (int j = 0; j < 64; j++) reg_m[j] = 8'h00;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      get(8'haf, 16'h0000, 1'b0, 1);
      t_foreign();
      t_poll();
      t_page();
      t_wrap();
      t_abort();
      t_protect();
      t_freeze();
      t_regs();
      print_verdict();
   end
endmodule
